//--- rtl/indicator_pkg.sv
package indicator_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned PULSE_MS        = 250;
  localparam int unsigned PAUSE_MS        = 750;
  localparam int unsigned FAST_HZ         = 10;
  localparam int unsigned SLOW_MHZ        = 500;   // 0.5 Hz in millihertz
  localparam int unsigned PULSE_CYC       = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned PAUSE_CYC       = CLK_HZ / 1000 * PAUSE_MS;
  // Half periods: each toggle of a flashing lamp
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / 1000 * (1000_000 / (2 * SLOW_MHZ));
  localparam int unsigned BLUE_HALF_CYC   = FAST_HALF_CYC * 2;
  // ---------------------------------------------------------------
  // Thresholds and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  LEVEL_ON_MIN    = 4'h4;
  localparam logic [3:0]  LEVEL_MAX       = 4'h8;
  localparam int unsigned BLUE_LAMPS      = 4;
  localparam logic        SSO_RESET       = 1'b0;
  // Connection pattern phases
  typedef enum logic [4:0] {
    PH_ON1  = 5'b00001,
    PH_OFF1 = 5'b00010,
    PH_ON2  = 5'b00100,
    PH_OFF2 = 5'b01000,
    PH_REST = 5'b10000
  } conn_phase_t;
endpackage : indicator_pkg

//--- rtl/light_curtain_status_indicators.sv
// How it works
// (R1) A connection error gives two 250 ms on/off pulses then 750 ms dark on both red lamps.
// (R2) A transmitter device error flashes the transmitter red lamp at 10 Hz.
// (R3) A receiver internal error flashes the receiver red lamp at 10 Hz.
// (R4) A receiver external error flashes the receiver red lamp at 0.5 Hz.
// (R5) Without errors the receiver red lamp is steady on while the switch outputs are off.
// (R6) The receiver green lamp is on while the switch outputs are on, following them one cycle later.
// (R7) Strength 1..8 shows on four blue lamps, lamp n flashing for 2n-1, steady for 2n.
// (R8) The switch outputs may only turn on once strength has reached level 4.
// (R9) A light reception fault drives the fourth blue lamp in a bright flash mode.
// (R10) Any fully interrupted beam switches the outputs off at once.
// (R11) The transmitter green lamp is on while the transmitter is powered and running.
`timescale 1ns/1ps
module light_curtain_status_indicators
  import indicator_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = indicator_pkg::PULSE_CYC,
  parameter int unsigned PAUSE_CYCLES = indicator_pkg::PAUSE_CYC,
  parameter int unsigned FAST_CYCLES  = indicator_pkg::FAST_HALF_CYC,
  parameter int unsigned SLOW_CYCLES  = indicator_pkg::SLOW_HALF_CYC,
  parameter int unsigned BLUE_CYCLES  = indicator_pkg::BLUE_HALF_CYC
) (
  input  wire logic       i_mclk,            // System clock, 40 MHz
  input  wire logic       i_resetn,          // Async reset, active low
  input  wire logic       i_tx_powered,      // Transmitter running
  input  wire logic       i_tx_dev_err,      // Transmitter device error
  input  wire logic       i_conn_err,        // Connection error
  input  wire logic       i_rx_int_err,      // Receiver internal error
  input  wire logic       i_rx_ext_err,      // Receiver external error
  input  wire logic       i_rx_fault,        // Light reception fault
  input  wire logic       i_beam_blocked,    // A beam fully interrupted
  input  wire logic [3:0] i_level,           // Reception strength 0..8
  output logic            o_tx_red,          // Transmitter red lamp
  output logic            o_tx_green,        // Transmitter green lamp
  output logic            o_rx_red,          // Receiver red lamp
  output logic            o_rx_green,        // Receiver green lamp
  output logic [3:0]      o_rx_blue,         // Receiver blue bar
  output logic            o_rx_blue4_bright, // Bright drive, fourth blue
  output logic            o_safety_switch_output // Switch outputs on
);
  import indicator_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] conn_cnt;
    conn_phase_t phase;
    logic [31:0] fast_cnt;
    logic        fast;
    logic [31:0] slow_cnt;
    logic        slow;
    logic [31:0] blue_cnt;
    logic        blue;
    logic        sso;
    logic        tx_red;
    logic        tx_green;
    logic        rx_red;
    logic        rx_green;
    logic [3:0]  rx_blue;
    logic        bright;
  } state_t;

  state_t st_q, st_d;
  logic   conn_lit;
  logic   phase_end;

  // Phase is lit during the two on slots only
  assign conn_lit  = (st_q.phase == PH_ON1) || (st_q.phase == PH_ON2);
  assign phase_end = (st_q.phase == PH_REST) ? (st_q.conn_cnt >= PAUSE_CYCLES - 1)
                                             : (st_q.conn_cnt >= PULSE_CYCLES - 1);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Connection pattern sequencer, restarted when no error so it opens lit
    if (!i_conn_err) begin
      st_d.conn_cnt = '0;
      st_d.phase    = PH_ON1;
    end else if (phase_end) begin // R1
      st_d.conn_cnt = '0;
      case (st_q.phase)
        PH_ON1:  st_d.phase = PH_OFF1;
        PH_OFF1: st_d.phase = PH_ON2;
        PH_ON2:  st_d.phase = PH_OFF2;
        PH_OFF2: st_d.phase = PH_REST;
        PH_REST: st_d.phase = PH_ON1;
        default: st_d.phase = PH_ON1;
      endcase
    end else begin
      st_d.conn_cnt = st_q.conn_cnt + 32'h1;
    end
    // Free-running flash generators, shared by all lamps to keep them in step
    if (st_q.fast_cnt >= FAST_CYCLES - 1) begin
      st_d.fast_cnt = '0;
      st_d.fast     = ~st_q.fast;
    end else begin
      st_d.fast_cnt = st_q.fast_cnt + 32'h1;
    end
    if (st_q.slow_cnt >= SLOW_CYCLES - 1) begin
      st_d.slow_cnt = '0;
      st_d.slow     = ~st_q.slow;
    end else begin
      st_d.slow_cnt = st_q.slow_cnt + 32'h1;
    end
    if (st_q.blue_cnt >= BLUE_CYCLES - 1) begin
      st_d.blue_cnt = '0;
      st_d.blue     = ~st_q.blue;
    end else begin
      st_d.blue_cnt = st_q.blue_cnt + 32'h1;
    end
    // Switch outputs: off wins over on, so a blocked beam is never masked
    if (i_beam_blocked || i_rx_int_err || i_rx_ext_err || i_conn_err || i_rx_fault) begin
      st_d.sso = 1'b0; // R10
    end else if (i_level >= LEVEL_ON_MIN) begin
      st_d.sso = 1'b1; // R8
    end
    // Transmitter lamps
    if (!i_tx_powered) begin
      st_d.tx_red   = 1'b0;
      st_d.tx_green = 1'b0;
    end else begin
      st_d.tx_green = 1'b1; // R11
      if (i_conn_err) begin
        st_d.tx_red = conn_lit; // R1
      end else if (i_tx_dev_err) begin
        st_d.tx_red = st_q.fast; // R2
      end else begin
        st_d.tx_red = 1'b0;
      end
    end
    // Receiver red: connection, internal, external, then output state
    if (i_conn_err) begin
      st_d.rx_red = conn_lit; // R1
    end else if (i_rx_int_err) begin
      st_d.rx_red = st_q.fast; // R3
    end else if (i_rx_ext_err) begin
      st_d.rx_red = st_q.slow; // R4
    end else begin
      st_d.rx_red = ~st_q.sso; // R5
    end
    st_d.rx_green = st_q.sso; // R6
    // Blue bar, lamp n for levels 2n-1 and 2n
    for (int n = 1; n <= BLUE_LAMPS; n++) begin
      if (i_level > 4'(2 * n)) begin
        st_d.rx_blue[n-1] = 1'b0;
      end else if (i_level == 4'(2 * n)) begin
        st_d.rx_blue[n-1] = 1'b1; // R7
      end else if (i_level == 4'(2 * n - 1)) begin
        st_d.rx_blue[n-1] = st_q.blue; // R7
      end else begin
        st_d.rx_blue[n-1] = 1'b0;
      end
    end
    // Reception fault overrides the bar; only the top lamp flashes bright
    st_d.bright = i_rx_fault; // R9
    if (i_rx_fault) begin
      st_d.rx_blue = {st_q.fast, 3'h0}; // R9
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q       <= '0;
      st_q.phase <= PH_ON1;
      st_q.sso   <= SSO_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tx_red               = st_q.tx_red;
  assign o_tx_green             = st_q.tx_green;
  assign o_rx_red               = st_q.rx_red;
  assign o_rx_green             = st_q.rx_green;
  assign o_rx_blue              = st_q.rx_blue;
  assign o_rx_blue4_bright      = st_q.bright;
  assign o_safety_switch_output = st_q.sso;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Blocked beam: outputs drop, then the green lamp goes dark a cycle later
  sequence s_off_then_dark;
    ##1 !o_safety_switch_output ##1 !o_rx_green;
  endsequence

  // A phase only advances once its own slot length has run out
  property p_conn_phase_len;
    @(posedge i_mclk) disable iff (!i_resetn)
      ($past(i_conn_err) && $changed(st_q.phase)) |->
        ($past(st_q.conn_cnt) == (($past(st_q.phase) == PH_REST) ? (PAUSE_CYCLES - 1)
                                                                  : (PULSE_CYCLES - 1)));
  endproperty
  a_conn_phase_len: assert property (p_conn_phase_len) else $error("conn phase count"); // R1

  property p_conn_lit;
    @(posedge i_mclk) disable iff (!i_resetn)
      ($past(i_conn_err) && i_conn_err) |-> ##1 (o_rx_red == $past(conn_lit));
  endproperty
  a_conn_lit: assert property (p_conn_lit) else $error("conn red pattern"); // R1

  property p_tx_fast;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_tx_powered && !i_conn_err && i_tx_dev_err) |=> (o_tx_red == $past(st_q.fast));
  endproperty
  a_tx_fast: assert property (p_tx_fast) else $error("tx fast flash"); // R2

  property p_rx_int;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!i_conn_err && i_rx_int_err) |=> (o_rx_red == $past(st_q.fast));
  endproperty
  a_rx_int: assert property (p_rx_int) else $error("rx internal flash"); // R3

  property p_rx_ext;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!i_conn_err && !i_rx_int_err && i_rx_ext_err) |=> (o_rx_red == $past(st_q.slow));
  endproperty
  a_rx_ext: assert property (p_rx_ext) else $error("rx external flash"); // R4

  property p_rx_off_red;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!i_conn_err && !i_rx_int_err && !i_rx_ext_err) |=> (o_rx_red == !$past(st_q.sso));
  endproperty
  a_rx_off_red: assert property (p_rx_off_red) else $error("rx red steady"); // R5

  property p_green;
    @(posedge i_mclk) disable iff (!i_resetn) ##1 (o_rx_green == $past(o_safety_switch_output));
  endproperty
  a_green: assert property (p_green) else $error("rx green state"); // R6

  property p_blue_even;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!i_rx_fault && i_level == 4'h2) |=> (o_rx_blue == 4'h1);
  endproperty
  a_blue_even: assert property (p_blue_even) else $error("blue steady level"); // R7

  property p_on_level;
    @(posedge i_mclk) disable iff (!i_resetn)
      $rose(o_safety_switch_output) |-> $past(i_level) >= LEVEL_ON_MIN;
  endproperty
  a_on_level: assert property (p_on_level) else $error("outputs on below level"); // R8

  property p_fault;
    @(posedge i_mclk) disable iff (!i_resetn)
      i_rx_fault |=> (o_rx_blue4_bright && o_rx_blue[2:0] == 3'h0);
  endproperty
  a_fault: assert property (p_fault) else $error("fault bright mode"); // R9

  property p_blocked;
    @(posedge i_mclk) disable iff (!i_resetn) i_beam_blocked |-> s_off_then_dark;
  endproperty
  a_blocked: assert property (p_blocked) else $error("outputs on while blocked"); // R10

  property p_tx_green;
    @(posedge i_mclk) disable iff (!i_resetn) 1'b1 |=> (o_tx_green == $past(i_tx_powered));
  endproperty
  a_tx_green: assert property (p_tx_green) else $error("tx green"); // R11

endmodule : light_curtain_status_indicators

//--- sim/safety_control_model.sv
`timescale 1ns/1ps
// Machine safety control: counts stops on each switch-off edge
module safety_control_model (
  input  wire logic i_mclk,  // System clock
  input  wire logic i_sso,   // Switch outputs from receiver
  output int        o_stops  // Stop requests seen
);
  logic sso_q = 1'b0;
  int   stops_q = 0;
  // A falling output must end the dangerous state
  always @(posedge i_mclk) begin
    sso_q <= i_sso;
    if (sso_q === 1'b1 && i_sso === 1'b0) begin
      stops_q <= stops_q + 1;
    end
  end
  assign o_stops = stops_q;
endmodule : safety_control_model

//--- sim/tb_light_curtain_status_indicators.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, a, b); end end
module tb_light_curtain_status_indicators;
  import indicator_pkg::*;
  // Short counts keep the run brief
  localparam int P = 5, Q = 15, F = 2, S = 40, B = 4;
  logic i_mclk = 0, i_resetn = 0, i_tx_powered = 0, i_tx_dev_err = 0, i_conn_err = 0;
  logic i_rx_int_err = 0, i_rx_ext_err = 0, i_rx_fault = 0, i_beam_blocked = 0;
  logic [3:0] i_level = 4'h0, o_rx_blue;
  logic o_tx_red, o_tx_green, o_rx_red, o_rx_green, o_rx_blue4_bright, o_safety_switch_output;
  int mismatches = 0, n_tests = 0, stops;
  always #12.5 i_mclk = ~i_mclk;
  light_curtain_status_indicators #(.PULSE_CYCLES(P), .PAUSE_CYCLES(Q), .FAST_CYCLES(F),
    .SLOW_CYCLES(S), .BLUE_CYCLES(B)) DUT (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_tx_powered(i_tx_powered), .i_tx_dev_err(i_tx_dev_err), .i_conn_err(i_conn_err),
    .i_rx_int_err(i_rx_int_err), .i_rx_ext_err(i_rx_ext_err), .i_rx_fault(i_rx_fault),
    .i_beam_blocked(i_beam_blocked), .i_level(i_level), .o_tx_red(o_tx_red),
    .o_tx_green(o_tx_green), .o_rx_red(o_rx_red), .o_rx_green(o_rx_green),
    .o_rx_blue(o_rx_blue), .o_rx_blue4_bright(o_rx_blue4_bright),
    .o_safety_switch_output(o_safety_switch_output));
  safety_control_model ctrl (.i_mclk(i_mclk), .i_sso(o_safety_switch_output), .o_stops(stops));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic sig(int k);
    logic [9:0] v;
    v = {o_safety_switch_output, o_rx_blue4_bright, o_rx_blue, o_rx_green, o_rx_red,
         o_tx_green, o_tx_red};
    return v[k];
  endfunction : sig
  task automatic cyc(int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  // Whole periods only, so the phase at entry does not matter
  task automatic meas(input int k, input int n, input int hi, input int ri);
    int h, r;
    logic p;
    h = 0;
    r = 0;
    @(negedge i_mclk) p = sig(k);
    repeat (n) begin
      @(negedge i_mclk);
      if (sig(k) === 1'b1) h++;
      if (sig(k) === 1'b1 && p === 1'b0) r++;
      p = sig(k);
    end
    `CHK(h, hi)
    `CHK(r, ri)
  endtask : meas
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_power;
    `CHK(o_tx_green, 1'b0)
    `CHK(o_safety_switch_output, 1'b0)
    @(posedge i_mclk) i_tx_powered <= 1'b1;
    cyc(3);
    `CHK(o_tx_green, 1'b1)
    $display("test power done");
  endtask : t_power
  task automatic t_levels;
    for (int l = 1; l <= 8; l++) begin
      @(posedge i_mclk) i_level <= 4'(l);
      cyc(4);
      if (l == 3) `CHK(o_safety_switch_output, 1'b0)
      if (l == 4) `CHK(o_safety_switch_output, 1'b1)
      meas(3 + (l + 1) / 2, 8 * B, (l % 2) ? 4 * B : 8 * B, (l % 2) ? 4 : 0);
    end
    `CHK(o_rx_green, 1'b1)
    `CHK(o_rx_red, 1'b0)
    $display("test levels done");
  endtask : t_levels
  task automatic t_block;
    int s;
    s = stops;
    @(posedge i_mclk) i_beam_blocked <= 1'b1;
    cyc(4);
    `CHK(o_safety_switch_output, 1'b0)
    `CHK(o_rx_green, 1'b0)
    `CHK(o_rx_red, 1'b1)
    `CHK(stops, s + 1)
    @(posedge i_mclk) i_beam_blocked <= 1'b0;
    cyc(4);
    `CHK(o_safety_switch_output, 1'b1)
    $display("test block done");
  endtask : t_block
  task automatic t_err;
    @(posedge i_mclk) i_conn_err <= 1'b1;
    cyc(4);
    `CHK(o_safety_switch_output, 1'b0)
    meas(0, 2 * (4 * P + Q), 4 * P, 4);
    meas(2, 4 * P + Q, 2 * P, 2);
    @(posedge i_mclk) begin
      i_conn_err <= 1'b0;
      i_tx_dev_err <= 1'b1;
      i_rx_int_err <= 1'b1;
    end
    cyc(4);
    meas(0, 40 * F, 20 * F, 20);
    meas(2, 40 * F, 20 * F, 20);
    @(posedge i_mclk) begin
      i_tx_dev_err <= 1'b0;
      i_rx_int_err <= 1'b0;
      i_rx_ext_err <= 1'b1;
    end
    cyc(4);
    meas(2, 4 * S, 2 * S, 2);
    `CHK(o_tx_red, 1'b0)
    @(posedge i_mclk) i_rx_ext_err <= 1'b0;
    cyc(4);
    $display("test errors done");
  endtask : t_err
  task automatic t_fault;
    @(posedge i_mclk) i_rx_fault <= 1'b1;
    cyc(4);
    `CHK(o_rx_blue4_bright, 1'b1)
    `CHK(o_safety_switch_output, 1'b0)
    meas(7, 40 * F, 20 * F, 20);
    @(posedge i_mclk) i_tx_powered <= 1'b0;
    cyc(3);
    `CHK(o_tx_green, 1'b0)
    $display("test fault done");
  endtask : t_fault
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Main sequence after a 12 cycle reset
  initial begin
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    cyc(2);
    t_power;
    t_levels;
    t_block;
    t_err;
    t_fault;
    print_verdict;
  end
  // Watchdog, well past the roughly 870 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_mclk);
    mismatches++;
    print_verdict;
  end
endmodule : tb_light_curtain_status_indicators
